// >>> logic/nv_ctrl.sv
// data nonvolatile memory unlock, control and word array
// assumes one instruction cycle per clk_i and same-clock register strobes
//
// Summary of operation
// R1 - the memory holds 16-bit words, each readable and writable singly.
// R2 - the larger variant holds 256 words ending at top address 7FFFFFh.
// R3 - the smaller variant holds 128 words ending at the same top address.
// R4 - a program or erase cycle runs without stalling the processor.
// R5 - the key register is write-only and only guards against stray cycles.
// R6 - software writes 55h then AAh to the key register back to back.
// R7 - after a good key pair the control register is writable one cycle.
// R8 - setting the start bit inside that cycle launches the chosen operation.
// R9 - the control upper byte holds the start bit and the error flag.
// R10 - the control lower byte chooses the operation type.
// R11 - software should mask interrupts across the whole unlock sequence.
// R12 - control writes outside the window are ignored; bad keys restart.
// R13 - hardware clears the start bit when the cycle finishes.
`timescale 1ns/100ps
`default_nettype none
`include "nv_ctrl_regs.svh"

module nv_ctrl #(
    parameter int WORDS      = `NV_WORDS_LARGE,
    parameter int CYCLE_CNT  = `NV_CYCLE_COUNT
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        key_wr_i,
    input  wire logic [7:0]  key_data_i,
    input  wire logic        ctrl_wr_i,
    input  wire logic [15:0] ctrl_data_i,
    input  wire logic        addr_wr_i,
    input  wire logic [23:0] addr_data_i,
    input  wire logic        wdata_wr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        rd_i,
    output logic      [15:0] nv_operation_control_o,
    output logic      [23:0] nv_target_address_o,
    output logic      [15:0] rdata_o,
    output logic             busy_o
);
    localparam int AW = $clog2(WORDS);
    localparam logic [23:0] TOP_ADDR = `NV_TOP_ADDR;

    // elaboration checks on sizes
    if (WORDS != `NV_WORDS_LARGE
        && WORDS != `NV_WORDS_SMALL) begin : g_bad_words
        $error("WORDS must be 256 or 128");
    end
    if (CYCLE_CNT < 1) begin : g_bad_cnt
        $error("CYCLE_CNT must be at least 1");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        nv_ctrl_pkg::key_state_t key;
        nv_ctrl_pkg::op_state_t  op;
        logic [15:0]             ctrl;
        logic [23:0]             addr;
        logic [15:0]             wbuf;
        logic [15:0]             rdata;
        logic [31:0]             cnt;
    } state_t;

    state_t st;
    state_t next_st;
    logic [15:0] mem [WORDS];
    logic        in_range;
    logic [AW-1:0] idx;
    logic        commit;
    logic        open_win;

    // R2 R3 window at top of program space
    assign in_range = st.addr[23:AW+1] == TOP_ADDR[23:AW+1];
    assign idx      = st.addr[AW:1];
    assign commit   = st.op == nv_ctrl_pkg::OP_COMMIT;
    assign open_win = st.key == nv_ctrl_pkg::KEY_OPEN;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        if (addr_wr_i) begin
            next_st.addr = addr_data_i;
        end
        if (wdata_wr_i) begin
            next_st.wbuf = wdata_i;
        end
        if (rd_i) begin
            next_st.rdata = in_range ? mem[idx] : 16'h0000;
        end
        // R6 R12 key sequencer
        case (st.key)
            nv_ctrl_pkg::KEY_IDLE: begin
                if (key_wr_i && key_data_i == `NV_KEY_FIRST) begin
                    next_st.key = nv_ctrl_pkg::KEY_GOT_FIRST;
                end
            end
            nv_ctrl_pkg::KEY_GOT_FIRST: begin
                if (key_wr_i && key_data_i == `NV_KEY_SECOND) begin
                    next_st.key = nv_ctrl_pkg::KEY_OPEN;
                end else if (key_wr_i && key_data_i == `NV_KEY_FIRST) begin
                    next_st.key = nv_ctrl_pkg::KEY_GOT_FIRST;
                end else begin
                    next_st.key = nv_ctrl_pkg::KEY_IDLE;
                end
            end
            nv_ctrl_pkg::KEY_OPEN: begin
                next_st.key = nv_ctrl_pkg::KEY_IDLE;
            end
            default: begin
                next_st.key = nv_ctrl_pkg::KEY_IDLE;
            end
        endcase
        // R7 R12 control write only in open window
        if (ctrl_wr_i && open_win && st.op == nv_ctrl_pkg::OP_IDLE) begin
            next_st.ctrl = ctrl_data_i & `NV_CTRL_WMASK;
            next_st.ctrl[`NV_ERR_BIT] = 1'b0;
        end
        // R4 R8 background cycle timer
        case (st.op)
            nv_ctrl_pkg::OP_IDLE: begin
                if (next_st.ctrl[`NV_START_BIT]) begin
                    next_st.op  = nv_ctrl_pkg::OP_BUSY;
                    next_st.cnt = 32'(CYCLE_CNT - 1);
                end
            end
            nv_ctrl_pkg::OP_BUSY: begin
                if (st.cnt == 32'h0000_0000) begin
                    next_st.op = nv_ctrl_pkg::OP_COMMIT;
                end else begin
                    next_st.cnt = st.cnt - 32'h0000_0001;
                end
            end
            nv_ctrl_pkg::OP_COMMIT: begin
                // R13 start bit self-clears; R9 flag on bad target
                next_st.op = nv_ctrl_pkg::OP_IDLE;
                next_st.ctrl[`NV_START_BIT] = 1'b0;
                next_st.ctrl[`NV_ERR_BIT]   = ~in_range;
            end
            default: begin
                next_st.op = nv_ctrl_pkg::OP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // word array
    // ****************************************************************
    // R1 R10 word write or erase by operation code
    always_ff @(posedge clk_i) begin
        if (commit && in_range) begin
            if (st.ctrl[`NV_OP_MSB:`NV_OP_LSB] == `NV_OP_ERASE_WORD) begin
                mem[idx] <= `NV_ERASED_WORD;
            end else if (st.ctrl[`NV_OP_MSB:`NV_OP_LSB]
                         == `NV_OP_WRITE_WORD) begin
                mem[idx] <= st.wbuf;
            end
        end
    end

    // R5 key register has no read path
    assign nv_operation_control_o = st.ctrl;
    assign nv_target_address_o    = st.addr;
    assign rdata_o                = st.rdata;
    assign busy_o                 = st.op != nv_ctrl_pkg::OP_IDLE;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_locked_ctrl: assert property ( // R12
        @(posedge clk_i) disable iff (sys_rst_i)
        (ctrl_wr_i && !open_win) |=> $stable(st.ctrl) || commit
            || $past(commit))
        else $error("control changed outside window");
    a_busy_refuse: assert property ( // R12
        @(posedge clk_i) disable iff (sys_rst_i)
        (ctrl_wr_i && busy_o)
            |=> $stable(st.ctrl[`NV_OP_MSB:`NV_OP_LSB]))
        else $error("op code changed while busy");
    a_window_one: assert property ( // R7
        @(posedge clk_i) disable iff (sys_rst_i)
        open_win |=> !open_win)
        else $error("window longer than one cycle");
    a_start_launch: assert property ( // R8
        @(posedge clk_i) disable iff (sys_rst_i)
        (open_win && ctrl_wr_i && ctrl_data_i[`NV_START_BIT] && !busy_o)
            |=> busy_o)
        else $error("start did not launch");
    a_start_clear: assert property ( // R13
        @(posedge clk_i) disable iff (sys_rst_i)
        commit |=> !nv_operation_control_o[`NV_START_BIT] && !busy_o)
        else $error("start bit not cleared");
    a_error_flag: assert property ( // R9
        @(posedge clk_i) disable iff (sys_rst_i)
        commit |=> nv_operation_control_o[`NV_ERR_BIT] == $past(!in_range))
        else $error("error flag wrong after cycle");
    a_key_pair: assert property ( // R6
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(open_win)
            |-> $past(key_wr_i) && $past(key_data_i) == `NV_KEY_SECOND)
        else $error("window without key");
endmodule
`default_nettype wire

// >>> logic/nv_ctrl_regs.svh
// register constants for the data nonvolatile memory control block
// assumes inclusion by bare name from the design file
`ifndef NV_CTRL_REGS_SVH
`define NV_CTRL_REGS_SVH
`define NV_KEY_FIRST      8'h55
`define NV_KEY_SECOND     8'hAA
`define NV_TOP_ADDR       24'h7FFFFF
`define NV_WORDS_LARGE    256
`define NV_WORDS_SMALL    128
`define NV_START_BIT      15
`define NV_ERR_BIT        13
`define NV_OP_LSB         0
`define NV_OP_MSB         7
`define NV_CYCLE_NS       4000
`define NV_CLK_NS         5
`define NV_CYCLE_COUNT    ((`NV_CYCLE_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)
`define NV_OP_ERASE_WORD  8'h58
`define NV_OP_WRITE_WORD  8'h04
`define NV_CTRL_WMASK     16'hA0FF
`define NV_ERASED_WORD    16'hFFFF
`endif

// >>> logic/nv_ctrl_pkg.sv
// types for the data nonvolatile memory control block
// assumes nv_ctrl_regs.svh is on the include path
package nv_ctrl_pkg;
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_OPEN
    } key_state_t;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_BUSY,
        OP_COMMIT
    } op_state_t;
endpackage

// >>> bench/tb_top.sv
// bench for the data nonvolatile memory control block
// assumes nv_ctrl with a shortened cycle count and 128 words
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int CNT = 4;
    localparam int WORDS = 128;
    localparam logic [23:0] BASE = 24'h7FFFFF - 24'(2 * WORDS) + 24'h000001;
    logic clk = 1'b0, rst = 1'b1, kw = 1'b0, cw = 1'b0;
    logic aw = 1'b0, ww = 1'b0, rd = 1'b0, busy;
    logic [7:0] kd = 8'h00;
    logic [15:0] cd = 16'h0000, wd = 16'h0000, ctl, rdat;
    logic [15:0] exp_ctl = 16'h0000;
    logic [23:0] ad = 24'h000000, tadr;
    logic [31:0] seed = 32'h23BB;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    logic [15:0] mem[int];
    always #2.5 clk = ~clk;
    nv_ctrl #(.WORDS(WORDS), .CYCLE_CNT(CNT)) DUT (.clk_i(clk),
        .sys_rst_i(rst), .key_wr_i(kw), .key_data_i(kd), .ctrl_wr_i(cw),
        .ctrl_data_i(cd), .addr_wr_i(aw), .addr_data_i(ad),
        .wdata_wr_i(ww), .wdata_i(wd), .rd_i(rd),
        .nv_operation_control_o(ctl), .nv_target_address_o(tadr),
        .rdata_o(rdat), .busy_o(busy));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one cycle of strobes, set on a falling edge
    task automatic drive(input logic k, c, input logic [7:0] kv,
                         input logic [15:0] cv);
        @(negedge clk);
        kw = k; kd = kv; cw = c; cd = cv; aw = 1'b0; ww = 1'b0; rd = 1'b0;
    endtask
    task automatic launch(input logic [7:0] k1, k2, input int gap,
                          input logic [15:0] c);
        drive(1'b1, 1'b0, k1, 16'h0000);
        drive(1'b1, 1'b0, k2, 16'h0000);
        repeat (gap) drive(1'b0, 1'b0, 8'h00, 16'h0000);
        drive(1'b0, 1'b1, 8'h00, c);
        drive(1'b0, 1'b0, 8'h00, 16'h0000);
    endtask
    task automatic run_op(input logic [7:0] k1, k2, input int gap,
                          input logic [15:0] c, input int w, input bit x);
        logic [15:0] d;
        logic [23:0] a;
        logic ok;
        int n;
        seed = lfsr(seed);
        d = seed[15:0];
        n = 0;
        a = (w < WORDS) ? BASE + 24'(w * 2) : 24'h000000;
        ok = (k1 == 8'h55 && k2 == 8'hAA && gap == 0);
        @(negedge clk);
        aw = 1'b1; ad = a; ww = 1'b1; wd = d;
        launch(k1, k2, gap, c);
        chk(tadr, a);
        chk(busy, ok && c[15]);
        if (ok) begin
            exp_ctl = c;
            exp_ctl[13] = 1'b0;
        end
        chk(ctl, exp_ctl);
        if (x) begin
            launch(8'h55, 8'hAA, 0, 16'h8058);
            n += 4;
        end
        while (busy === 1'b1 && n < CNT + 10) begin
            drive(1'b0, 1'b0, 8'h00, 16'h0000);
            n++;
        end
        chk(24'(n), (ok && c[15]) ? 24'(CNT + 1) : 24'h0);
        exp_ctl[15] = 1'b0;
        if (ok && c[15]) exp_ctl[13] = (w >= WORDS);
        chk(ctl, exp_ctl);
        if (ok && c == 16'h8004 && w < WORDS) mem[w] = d;
        if (ok && c == 16'h8058 && w < WORDS) mem[w] = 16'hFFFF;
        @(negedge clk);
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        if (w >= WORDS) chk(rdat, 16'h0000);
        else if (mem.exists(w)) chk(rdat, mem[w]);
    endtask
    // ****************************************
    // main sequence: table of key orders and op codes
    // ****************************************
    logic [7:0] ka[8] = '{8'h55, 8'h55, 8'h55, 8'hAA,
                          8'h55, 8'h55, 8'h55, 8'h55};
    logic [7:0] kb[8] = '{8'hAA, 8'hAA, 8'hAA, 8'h55,
                          8'hAA, 8'h56, 8'h55, 8'hAA};
    logic [15:0] cv[8] = '{16'h8004, 16'h8058, 16'h8004, 16'h8004,
                           16'h8058, 16'h8058, 16'h8058, 16'h0004};
    int gp[8] = '{0, 0, 0, 0, 1, 0, 0, 0};
    bit xi[8] = '{0, 0, 1, 0, 0, 0, 0, 0};
    initial begin
        int w;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk({busy, ctl}, 17'h0);
        chk(tadr ^ rdat, 24'h0);
        for (int r = 0; r < 3; r++) begin
            seed = lfsr(seed);
            w = int'(seed[6:0]) % WORDS;
            for (int i = 0; i < 8; i++)
                run_op(ka[i], kb[i], gp[i], cv[i], w, xi[i]);
            $display("round %0d done, mismatches %0d", r, error_cnt);
        end
        run_op(8'h55, 8'hAA, 0, 16'h8004, WORDS + 1, 1'b0);
        $display("out of range test done, mismatches %0d", error_cnt);
        wrap_up();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
endmodule
`default_nettype wire
